// ==== inc/sbc_pkg.sv ====
//------------------------------------------------------------
// Purpose: shared types and constants for skip/branch control
// Assumes: one core clock, program counter counts in words
// Notes:   flag positions follow the processor flag register layout
//------------------------------------------------------------
package sbc_pkg;

  localparam int PC_W  = 16;
  localparam int OFS_W = 7;

  // flag register bit positions
  localparam logic [2:0] FLAG_CARRY_POS = 3'h0;
  localparam logic [2:0] FLAG_ZERO_POS  = 3'h1;

  // program counter steps in words
  localparam logic [1:0] STEP_NEXT       = 2'h1;
  localparam logic [1:0] STEP_SKIP_SHORT = 2'h2;
  localparam logic [1:0] STEP_SKIP_LONG  = 2'h3;

  // execution time in core cycles
  localparam logic [1:0] CYC_UNTAKEN      = 2'h1;
  localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
  localparam logic [1:0] CYC_SKIP_SHORT   = 2'h2;
  localparam logic [1:0] CYC_SKIP_LONG    = 2'h3;

  typedef enum logic [3:0] {
    OP_SKIP_IF_REG_BIT_LOW      = 4'h0,
    OP_SKIP_IF_REG_BIT_HIGH     = 4'h1,
    OP_SKIP_IF_PORT_BIT_LOW     = 4'h2,
    OP_SKIP_IF_PORT_BIT_HIGH    = 4'h3,
    OP_BRANCH_ON_FLAG_HIGH      = 4'h4,
    OP_BRANCH_ON_FLAG_LOW       = 4'h5,
    OP_BRANCH_ON_EQUAL          = 4'h6,
    OP_BRANCH_ON_UNEQUAL        = 4'h7,
    OP_BRANCH_ON_BORROW_HIGH    = 4'h8,
    OP_BRANCH_ON_BORROW_LOW     = 4'h9,
    OP_BRANCH_UNSIGNED_NOT_LOWER = 4'hA
  } sbc_op_type;

  typedef struct packed {
    logic [3:0]       op;
    logic [7:0]       reg_val;
    logic [7:0]       port_val;
    logic [2:0]       bit_sel;
    logic [7:0]       flags;
    logic [OFS_W-1:0] offset;
    logic [PC_W-1:0]  pc;
    logic             next_long;
  } sbc_req_type;

  typedef struct packed {
    logic [PC_W-1:0] pc_next;
    logic            taken;
    logic [1:0]      cycles;
    logic            bad_op;
  } sbc_res_type;

endpackage : sbc_pkg

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for skip and branch control
// Assumes: inputs change on the falling edge of clk_sys
// Notes:   expected PCs are literals or br(); cycles use package CYC constants except in flag branches
module tb_top
  import sbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // signals
  // ----------
  logic        clk_sys;
  logic        rst_b;
  logic        req_valid;
  logic        busy_q;
  logic        done_q;
  logic        flag_wr_q;
  sbc_req_type req;
  sbc_res_type res_q;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc_cnt = 0;

  sbc_core i_sbc_core (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .busy_q(busy_q), .done_q(done_q), .res_q(res_q), .flag_wr_q(flag_wr_q));
  // ----------
  // helpers
  // ----------
  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk

  function automatic logic [15:0] br(input logic [15:0] pc, input logic [6:0] o);
    return pc + {{9{o[6]}}, o} + 16'h0001;
  endfunction : br

  // one request, then latency and result compared
  task automatic run_op(input sbc_op_type op, input logic [7:0] rv, pv, input logic [2:0] b,
      input logic [7:0] f, input logic [6:0] o, input logic [15:0] pc, input logic nl, tk,
      input logic [1:0] cy, input logic [15:0] pn);
    int n;
    @(negedge clk_sys);
    req = '{op, rv, pv, b, f, o, pc, nl};
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    chk(busy_q === (cy != CYC_UNTAKEN), "busy level");
    n = 1;
    while (done_q !== 1'b1 && n < 6) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n == cy, "done latency");
    chk(res_q.pc_next === pn && res_q.taken === tk && res_q.cycles === cy && res_q.bad_op === 1'b0, "result");
    chk(flag_wr_q === 1'b0, "flag write");
  endtask : run_op

  // fixed-flag branch; bit_sel set to 7 so it must be ignored
  task automatic br_case(input sbc_op_type op, input logic [7:0] f, input logic tk);
    run_op(op, 8'h00, 8'h00, 3'h7, f, 7'h05, 16'hFFFC, 1'b0, tk, tk ? CYC_BRANCH_TAKEN : CYC_UNTAKEN,
      tk ? br(16'hFFFC, 7'h05) : 16'hFFFD);
  endtask : br_case
  // ----------
  // scenarios
  // ----------
  task automatic t_reg_skips;
    run_op(OP_SKIP_IF_REG_BIT_LOW, 8'hF7, 8'h08, 3'h3, 8'h00, 7'h00, 16'h0100, 1'b0, 1'b1, CYC_SKIP_SHORT, 16'h0102);
    run_op(OP_SKIP_IF_REG_BIT_LOW, 8'hF7, 8'h08, 3'h3, 8'h00, 7'h00, 16'h0100, 1'b1, 1'b1, CYC_SKIP_LONG, 16'h0103);
    run_op(OP_SKIP_IF_REG_BIT_LOW, 8'h08, 8'hF7, 3'h3, 8'h00, 7'h00, 16'h0100, 1'b1, 1'b0, CYC_UNTAKEN, 16'h0101);
    run_op(OP_SKIP_IF_REG_BIT_HIGH, 8'h80, 8'h7F, 3'h7, 8'h00, 7'h00, 16'hFFFE, 1'b1, 1'b1, CYC_SKIP_LONG, 16'h0001);
    run_op(OP_SKIP_IF_REG_BIT_HIGH, 8'h7F, 8'h80, 3'h7, 8'h00, 7'h00, 16'h0100, 1'b0, 1'b0, CYC_UNTAKEN, 16'h0101);
  endtask : t_reg_skips

  task automatic t_port_skips;
    run_op(OP_SKIP_IF_PORT_BIT_LOW, 8'h01, 8'hFE, 3'h0, 8'h00, 7'h00, 16'h0200, 1'b0, 1'b1, CYC_SKIP_SHORT, 16'h0202);
    run_op(OP_SKIP_IF_PORT_BIT_LOW, 8'hFE, 8'h01, 3'h0, 8'h00, 7'h00, 16'h0200, 1'b0, 1'b0, CYC_UNTAKEN, 16'h0201);
    run_op(OP_SKIP_IF_PORT_BIT_HIGH, 8'hDF, 8'h20, 3'h5, 8'h00, 7'h00, 16'h0200, 1'b1, 1'b1, CYC_SKIP_LONG, 16'h0203);
    run_op(OP_SKIP_IF_PORT_BIT_HIGH, 8'h20, 8'hDF, 3'h5, 8'h00, 7'h00, 16'h0200, 1'b0, 1'b0, CYC_UNTAKEN, 16'h0201);
  endtask : t_port_skips

  task automatic t_flag_branches;
    run_op(OP_BRANCH_ON_FLAG_HIGH, 8'h00, 8'h00, 3'h6, 8'h40, 7'h40, 16'h0010, 1'b0, 1'b1, 2'h2, br(16'h0010, 7'h40));
    run_op(OP_BRANCH_ON_FLAG_HIGH, 8'h00, 8'h00, 3'h6, 8'hBF, 7'h40, 16'h0010, 1'b0, 1'b0, 2'h1, 16'h0011);
    run_op(OP_BRANCH_ON_FLAG_LOW, 8'h00, 8'h00, 3'h6, 8'hBF, 7'h3F, 16'h0010, 1'b0, 1'b1, 2'h2, br(16'h0010, 7'h3F));
    run_op(OP_BRANCH_ON_FLAG_LOW, 8'h00, 8'h00, 3'h6, 8'h40, 7'h3F, 16'h0010, 1'b0, 1'b0, 2'h1, 16'h0011);
  endtask : t_flag_branches

  task automatic t_named_branches;
    br_case(OP_BRANCH_ON_EQUAL, 8'h02, 1'b1);
    br_case(OP_BRANCH_ON_EQUAL, 8'hFD, 1'b0);
    br_case(OP_BRANCH_ON_UNEQUAL, 8'hFD, 1'b1);
    br_case(OP_BRANCH_ON_UNEQUAL, 8'h02, 1'b0);
    br_case(OP_BRANCH_ON_BORROW_HIGH, 8'h01, 1'b1);
    br_case(OP_BRANCH_ON_BORROW_HIGH, 8'hFE, 1'b0);
    br_case(OP_BRANCH_ON_BORROW_LOW, 8'hFE, 1'b1);
    br_case(OP_BRANCH_ON_BORROW_LOW, 8'h01, 1'b0);
    br_case(OP_BRANCH_UNSIGNED_NOT_LOWER, 8'hFE, 1'b1);
    br_case(OP_BRANCH_UNSIGNED_NOT_LOWER, 8'h01, 1'b0);
  endtask : t_named_branches

  // request held while busy must not be taken; then an unknown op
  task automatic t_refuse;
    @(negedge clk_sys);
    req = '{OP_BRANCH_ON_EQUAL, 8'h00, 8'h00, 3'h0, 8'h02, 7'h10, 16'h0200, 1'b0};
    req_valid = 1'b1;
    @(negedge clk_sys);
    req.op = 4'hB;
    @(negedge clk_sys);
    req_valid = 1'b0;
    chk(done_q === 1'b1 && res_q.pc_next === 16'h0211 && res_q.bad_op === 1'b0, "busy refuse");
    @(negedge clk_sys);
    chk(done_q === 1'b0, "queued request");
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    chk(done_q === 1'b1 && res_q.bad_op === 1'b1 && res_q.pc_next === 16'h0201, "bad op");
  endtask : t_refuse
  // ----------
  // clock, timeout, sequence
  // ----------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 2000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (12) @(negedge clk_sys);
    chk(busy_q === 1'b0 && done_q === 1'b0 && res_q === '0 && flag_wr_q === 1'b0, "reset state");
    rst_b = 1'b1;
    t_reg_skips();
    t_port_skips();
    t_flag_branches();
    t_named_branches();
    t_refuse();
    close_out();
  end
endmodule : tb_top

// ==== src/sbc_cond_eval.sv ====
//------------------------------------------------------------
// Purpose: condition test for skip and branch operations
// Assumes: request fields stable while evaluated
// Notes:   purely combinational
//------------------------------------------------------------
module sbc_cond_eval
  import sbc_pkg::*;
(
  // request
  input  sbc_req_type req,
  // verdict
  output logic        taken,
  output logic        is_skip,
  output logic        legal
);

  wire reg_bit   = req.reg_val[req.bit_sel];
  wire port_bit  = req.port_val[req.bit_sel];
  wire flag_bit  = req.flags[req.bit_sel];
  wire zero_bit  = req.flags[FLAG_ZERO_POS];
  wire carry_bit = req.flags[FLAG_CARRY_POS];

  always_comb begin
    taken   = 1'b0;
    is_skip = 1'b0;
    legal   = 1'b1;
    case (req.op)
      OP_SKIP_IF_REG_BIT_LOW: begin
        taken   = ~reg_bit;
        is_skip = 1'b1;
      end
      OP_SKIP_IF_REG_BIT_HIGH: begin
        taken   = reg_bit;
        is_skip = 1'b1;
      end
      OP_SKIP_IF_PORT_BIT_LOW: begin
        taken   = ~port_bit;
        is_skip = 1'b1;
      end
      OP_SKIP_IF_PORT_BIT_HIGH: begin
        taken   = port_bit;
        is_skip = 1'b1;
      end
      OP_BRANCH_ON_FLAG_HIGH:       taken = flag_bit;
      OP_BRANCH_ON_FLAG_LOW:        taken = ~flag_bit;
      OP_BRANCH_ON_EQUAL:           taken = zero_bit;
      OP_BRANCH_ON_UNEQUAL:         taken = ~zero_bit;
      OP_BRANCH_ON_BORROW_HIGH:     taken = carry_bit;
      OP_BRANCH_ON_BORROW_LOW:      taken = ~carry_bit;
      OP_BRANCH_UNSIGNED_NOT_LOWER: taken = ~carry_bit;
      default:                      legal = 1'b0;
    endcase
  end

endmodule : sbc_cond_eval

// ==== src/sbc_core.sv ====
//------------------------------------------------------------
// Purpose: skip and conditional branch control of the core
// Assumes: requests come from decode logic on clk_sys
// Notes:   bit_sel doubles as the flag index for flag branches
//------------------------------------------------------------
module sbc_core
  import sbc_pkg::*;
(
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  rst_b,
  // request from decode
  input  wire logic  req_valid,
  input  sbc_req_type req,
  // result to fetch
  output logic        busy_q,
  output logic        done_q,
  output sbc_res_type res_q,
  output logic        flag_wr_q
);

  //------------------------------------------------------------
  // arithmetic
  //------------------------------------------------------------
  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc, input logic [1:0] step);
    pc_step = pc + PC_W'(step);
  endfunction : pc_step

  function automatic logic [PC_W-1:0] pc_rel(input logic [PC_W-1:0] pc, input logic [OFS_W-1:0] ofs);
    pc_rel = pc + {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs} + PC_W'(1);
  endfunction : pc_rel

  //------------------------------------------------------------
  // decode
  //------------------------------------------------------------
  typedef enum logic {
    S_IDLE = 1'b0,
    S_WAIT = 1'b1
  } sbc_state_type;

  sbc_state_type   state_q;
  sbc_state_type   state_d;
  logic [1:0]      cnt_q;
  logic            taken;
  logic            is_skip;
  logic            legal;

  sbc_cond_eval u_eval (
    .req     (req),
    .taken   (taken),
    .is_skip (is_skip),
    .legal   (legal)
  );

  wire             accept      = req_valid && (state_q == S_IDLE);
  wire             go          = taken && legal;
  wire [1:0]       skip_step   = req.next_long ? STEP_SKIP_LONG : STEP_SKIP_SHORT;
  wire [1:0]       skip_cyc    = req.next_long ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
  wire [PC_W-1:0]  skip_pc     = pc_step(req.pc, skip_step);
  wire [PC_W-1:0]  branch_pc   = pc_rel(req.pc, req.offset);
  wire [PC_W-1:0]  seq_pc      = pc_step(req.pc, STEP_NEXT);
  wire [PC_W-1:0]  target_pc   = !go ? seq_pc : (is_skip ? skip_pc : branch_pc);
  wire [1:0]       cycles      = !go ? CYC_UNTAKEN : (is_skip ? skip_cyc : CYC_BRANCH_TAKEN);
  wire             finish_now  = (state_q == S_IDLE) ? (accept && cycles == CYC_UNTAKEN)
                                                     : (cnt_q == 2'h1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (accept && cycles != CYC_UNTAKEN) state_d = S_WAIT;
      S_WAIT: if (cnt_q == 2'h1) state_d = S_IDLE;
    endcase
  end

  //------------------------------------------------------------
  // sequencing
  //------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      cnt_q   <= 2'h0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= accept ? cycles - 2'h1 : (cnt_q != 2'h0 ? cnt_q - 2'h1 : 2'h0);
      busy_q  <= (state_d == S_WAIT);
      done_q  <= finish_now;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      res_q     <= '0;
      flag_wr_q <= 1'b0;
    end else begin
      flag_wr_q <= 1'b0;
      if (accept) res_q <= '{pc_next: target_pc, taken: go, cycles: cycles, bad_op: !legal};
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  wire           acc_reg_low  = accept && req.op == OP_SKIP_IF_REG_BIT_LOW;
  wire           acc_reg_high = accept && req.op == OP_SKIP_IF_REG_BIT_HIGH;
  wire           acc_prt_low  = accept && req.op == OP_SKIP_IF_PORT_BIT_LOW;
  wire           acc_prt_high = accept && req.op == OP_SKIP_IF_PORT_BIT_HIGH;
  wire [PC_W-1:0] exp_skip    = req.pc + (req.next_long ? PC_W'(3) : PC_W'(2));
  wire [PC_W-1:0] exp_rel     = req.pc + {{(PC_W-OFS_W){req.offset[OFS_W-1]}}, req.offset} + PC_W'(1);

  reg_low_skip_a: assert property (acc_reg_low && !req.reg_val[req.bit_sel] && !req.next_long
    |-> ##1 res_q.pc_next == $past(exp_skip) ##1 done_q)
    else $error("reg bit low skip wrong");
  reg_high_skip_a: assert property (acc_reg_high && req.reg_val[req.bit_sel]
    |=> res_q.taken && res_q.pc_next == $past(exp_skip))
    else $error("reg bit high skip wrong");
  port_low_skip_a: assert property (acc_prt_low && !req.port_val[req.bit_sel] && req.next_long
    |-> ##1 !done_q ##1 !done_q ##1 done_q && res_q.pc_next == $past(exp_skip, 3))
    else $error("port bit low skip wrong");
  flag_high_br_a: assert property (accept && req.op == OP_BRANCH_ON_FLAG_HIGH && req.flags[req.bit_sel]
    |=> res_q.pc_next == $past(exp_rel))
    else $error("flag high branch target wrong");
  flag_low_br_a: assert property (accept && req.op == OP_BRANCH_ON_FLAG_LOW
    |-> if (req.flags[req.bit_sel]) (##1 done_q) else (##1 !done_q ##1 done_q))
    else $error("flag low branch timing wrong");
  equal_br_a: assert property (accept && (req.op == OP_BRANCH_ON_EQUAL || req.op == OP_BRANCH_ON_UNEQUAL)
    |=> res_q.taken == ($past(req.flags[FLAG_ZERO_POS]) == ($past(req.op) == OP_BRANCH_ON_EQUAL)))
    else $error("equal branch condition wrong");
  carry_high_br_a: assert property (accept && req.op == OP_BRANCH_ON_BORROW_HIGH && !req.flags[FLAG_CARRY_POS]
    |=> done_q && !res_q.taken && res_q.pc_next == $past(req.pc) + PC_W'(1))
    else $error("carry high branch untaken wrong");
  carry_low_br_a: assert property (accept && req.op == OP_BRANCH_ON_BORROW_LOW && !req.flags[FLAG_CARRY_POS]
    |=> res_q.taken && res_q.pc_next == $past(exp_rel) ##1 done_q)
    else $error("carry low branch wrong");
  not_lower_br_a: assert property (accept && req.op == OP_BRANCH_UNSIGNED_NOT_LOWER
    |=> res_q.taken == !$past(req.flags[FLAG_CARRY_POS]) && res_q.cycles == ($past(req.flags[FLAG_CARRY_POS])
        ? CYC_UNTAKEN : CYC_BRANCH_TAKEN))
    else $error("not lower branch wrong");
  port_high_skip_a: assert property (acc_prt_high
    |=> res_q.taken == $past(req.port_val[req.bit_sel]))
    else $error("port bit high skip wrong");
  no_flag_wr_a: assert property (done_q |-> !flag_wr_q && $stable(flag_wr_q))
    else $error("flag write seen");

  cov_skip_long_c:  cover property (accept && is_skip && go && req.next_long ##3 done_q);
  cov_branch_tk_c:  cover property (accept && !is_skip && go ##2 done_q);
  cov_untaken_c:    cover property (accept && !go ##1 done_q);

endmodule : sbc_core
